// ### src/ppa_pkg.sv
// Shared constants of the parallel port address, pin and buffer status block
package ppa_pkg;

    // ========================================================================
    // Register offsets (word index on the plain register port)
    localparam logic [3:0] OFS_TARGET = 4'h0;
    localparam logic [3:0] OFS_PIN_EN = 4'h1;
    localparam logic [3:0] OFS_BUF_STATE = 4'h2;
    localparam logic [3:0] OFS_PAD_CFG = 4'h3;
    localparam logic [3:0] OFS_IN_WORD_ONE = 4'h4;
    localparam logic [3:0] OFS_IN_WORD_TWO = 4'h5;
    localparam logic [3:0] OFS_OUT_WORD_ONE = 4'h6;
    localparam logic [3:0] OFS_OUT_WORD_TWO = 4'h7;
    localparam logic [3:0] OFS_CONTROL = 4'h8;
    localparam logic [3:0] OFS_IRQ_STATUS = 4'h9;
    localparam logic [3:0] OFS_IRQ_MASK = 4'hA;

    // ========================================================================
    // Field positions
    localparam int CS_CTL_BIT = 14;
    localparam int SEL_PAD_BIT = 14;
    localparam int IN_ALL_FULL_BIT = 15;
    localparam int IN_OVF_BIT = 14;
    localparam int IN_FULL_LSB = 8;
    localparam int OUT_ALL_EMPTY_BIT = 7;
    localparam int OUT_UNF_BIT = 6;
    localparam int OUT_EMPTY_LSB = 0;
    localparam int PORT_ON_BIT = 15;
    localparam int IRQ_SEL_LSB = 13;
    localparam int MODE_LSB = 8;
    localparam int IRQ_OVF_BIT = 0;
    localparam int IRQ_UNF_BIT = 1;
    localparam int IRQ_CYC_BIT = 2;
    localparam int IRQ_BITS = 3;
    localparam int PAD_CFG_BITS = 3;

    // ========================================================================
    // Encodings
    localparam logic [1:0] MODE_LEGACY = 2'h0;
    localparam logic [1:0] MODE_ADDRESSED = 2'h1;
    localparam logic [1:0] IRQ_OFF = 2'h0;
    localparam logic [1:0] IRQ_EACH_CYCLE = 2'h1;
    localparam logic [1:0] IRQ_STALL = 2'h2;
    localparam logic [1:0] IRQ_LAST_SLOT = 2'h3;
    localparam logic [1:0] LAST_SLOT = 2'h3;

    // ========================================================================
    // Reset values
    localparam logic RST_EMPTY = 1'h1;
    localparam logic RST_OE_N = 1'h1;

endpackage

// ### src/ppa_byte_slot.sv
// One byte slot: an input byte with its full flag, an output byte with its empty flag
`timescale 1ns/1ns
module ppa_byte_slot
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // External side
    input wire logic i_ext_wr_hit,
    input wire logic i_ext_rd_hit,
    input wire logic [7:0] i_ext_byte,
    // Software side
    input wire logic i_sw_in_take,
    input wire logic i_sw_out_load,
    input wire logic [7:0] i_sw_byte,
    // State
    output logic [7:0] o_in_byte,
    output logic o_in_full,
    output logic [7:0] o_out_byte,
    output logic o_out_empty
);

    typedef struct packed {
        logic [7:0] in_byte;
        logic in_full;
        logic [7:0] out_byte;
        logic out_empty;
    } ppa_slot_s;

    ppa_slot_s st_r;
    ppa_slot_s st_nxt;

    // ========================================================================
    // Next state; a software load beats the external empty set in the same cycle, and a write to a full slot is dropped even if software takes it
    always_comb
    begin
        st_nxt = st_r;
        if (i_sw_in_take)
        begin
            st_nxt.in_full = 1'b0; // [R09]
        end
        if (i_ext_wr_hit && !st_r.in_full)
        begin
            st_nxt.in_byte = i_ext_byte; // [R16]
            st_nxt.in_full = 1'b1; // [R16]
        end
        if (i_ext_rd_hit)
        begin
            st_nxt.out_empty = 1'b1;
        end
        if (i_sw_out_load)
        begin
            st_nxt.out_byte = i_sw_byte;
            st_nxt.out_empty = 1'b0; // [R12]
        end
    end

    // State register
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st_r <= '0;
            st_r.out_empty <= ppa_pkg::RST_EMPTY;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign o_in_byte = st_r.in_byte;
    assign o_in_full = st_r.in_full;
    assign o_out_byte = st_r.out_byte;
    assign o_out_empty = st_r.out_empty;

endmodule

// ### src/ppa_port.sv
// Parallel port address, pad enable and slave buffer status block
//
// Function
// R01: Address register bit 14 drives chip select one active or inactive.
// R02: Address register bits 10..0 hold the destination address driven on pads.
// R03: Pad enable bit 14 makes the chip select pad a port pad.
// R04: Pad enable bits 10..2 make matching pads port address lines.
// R05: Pad enable bits 1..0 make the two low pads address or latch pads.
// R06: Unused bits 15 and 13..11 of address and pad enable read zero.
// R07: Input-all-full reads one only while all four input slots are full.
// R08: Write to a full input slot sets sticky overflow until software clears.
// R09: Per-slot full flag set on data, cleared when software reads that slot.
// R10: Output-all-empty reads one only while all four output slots are empty.
// R11: Read of an empty output slot sets sticky underflow until software clears.
// R12: Per-slot empty flag clears when software writes that slot.
// R13: Two address lines pick slots 0..3: low/high byte of word one, two.
// R14: Mode field 01 selects the addressed slave mode using two address lines.
// R15: Interrupt select 11 fires on slot 3 access, buffered or addressed.
// R16: External write with chip select stores byte and sets full, else discards.
// R17: Master holds chip select and address stable around each strobe.
`timescale 1ns/1ns
module ppa_port
#(
    parameter int LOC_W = 11
)
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // Register port
    input wire logic [3:0] i_addr,
    input wire logic [15:0] i_wr_data,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rd_data,
    // External parallel master
    input wire logic i_ext_cs,
    input wire logic i_ext_rd,
    input wire logic i_ext_wr,
    input wire logic [1:0] i_buffer_select_lines,
    input wire logic [7:0] i_ext_data,
    output logic [7:0] o_ext_data,
    output logic o_ext_data_oe_n,
    // Pads
    output logic [10:0] o_location_pins,
    output logic [10:0] o_location_pad_sel,
    output logic o_chip_select_one_pin,
    output logic o_chip_select_pad_sel,
    output logic o_ttl_input_sel,
    // Interrupt
    output logic o_irq
);

    // ========================================================================
    // Elaboration check
    if (LOC_W != 11)
    begin : g_bad_width
        $error("ppa_port: location width must be 11");
    end

    typedef struct packed {
        logic chip_select_one_ctl;
        logic [10:0] location;
        logic select_pad_enable;
        logic [10:0] location_pad_enables;
        logic [2:0] pad_cfg;
        logic port_on;
        logic [1:0] interrupt_request_select;
        logic [1:0] port_mode_field;
        logic input_overflow;
        logic output_underflow;
        logic [2:0] irq_status;
        logic [2:0] irq_mask;
        logic wr_prev;
        logic rd_prev;
        logic [1:0] in_ptr;
        logic [1:0] out_ptr;
        logic [15:0] rd_data;
        logic [7:0] ext_dout;
        logic ext_oe_n;
        logic irq;
    } ppa_state_s;

    ppa_state_s st_r;
    ppa_state_s st_nxt;

    logic [7:0] in_byte [4];
    logic [7:0] out_byte [4];
    logic [3:0] input_buffer_full_flags;
    logic [3:0] output_buffer_empty_flags;
    logic [3:0] sw_in_take;
    logic [3:0] sw_out_load;
    logic [3:0] ext_wr_hit_v;
    logic [3:0] ext_rd_hit_v;
    logic slave_on;
    logic wr_hit;
    logic rd_hit;
    logic [1:0] wr_sel;
    logic [1:0] rd_sel;
    logic input_all_full;
    logic output_all_empty;
    logic ev_ovf;
    logic ev_unf;
    logic ev_cyc;
    logic [15:0] status_word;

    // ========================================================================
    // External strobe decode
    assign slave_on = st_r.port_on && !st_r.port_mode_field[1];
    assign wr_hit = slave_on && i_ext_cs && i_ext_wr && !st_r.wr_prev; // [R16] [R17]
    assign rd_hit = slave_on && i_ext_cs && i_ext_rd && !st_r.rd_prev; // [R17]

    // Slot choice: address lines in addressed mode, running pointer otherwise
    always_comb
    begin
        if (st_r.port_mode_field == ppa_pkg::MODE_ADDRESSED) // [R14]
        begin
            wr_sel = i_buffer_select_lines; // [R13]
            rd_sel = i_buffer_select_lines; // [R13]
        end
        else
        begin
            wr_sel = st_r.in_ptr;
            rd_sel = st_r.out_ptr;
        end
    end

    // Status summaries
    assign input_all_full = &input_buffer_full_flags; // [R07]
    assign output_all_empty = &output_buffer_empty_flags; // [R10]
    assign ev_ovf = wr_hit && input_buffer_full_flags[wr_sel]; // [R08]
    assign ev_unf = rd_hit && output_buffer_empty_flags[rd_sel]; // [R11]

    // Cycle interrupt event per request select
    always_comb
    begin
        case (st_r.interrupt_request_select)
            ppa_pkg::IRQ_EACH_CYCLE: ev_cyc = wr_hit || rd_hit;
            ppa_pkg::IRQ_LAST_SLOT: ev_cyc = (wr_hit && wr_sel == ppa_pkg::LAST_SLOT)
                || (rd_hit && rd_sel == ppa_pkg::LAST_SLOT); // [R15]
            default: ev_cyc = 1'b0;
        endcase
    end

    // Buffer state word
    always_comb
    begin
        status_word = '0;
        status_word[ppa_pkg::IN_ALL_FULL_BIT] = input_all_full; // [R07]
        status_word[ppa_pkg::IN_OVF_BIT] = st_r.input_overflow;
        status_word[ppa_pkg::IN_FULL_LSB +: 4] = input_buffer_full_flags;
        status_word[ppa_pkg::OUT_ALL_EMPTY_BIT] = output_all_empty; // [R10]
        status_word[ppa_pkg::OUT_UNF_BIT] = st_r.output_underflow;
        status_word[ppa_pkg::OUT_EMPTY_LSB +: 4] = output_buffer_empty_flags;
    end

    // ========================================================================
    // Byte slots, two per word, low byte first
    for (genvar g = 0; g < 4; g++)
    begin : g_slot
        assign ext_wr_hit_v[g] = wr_hit && (wr_sel == 2'(g));
        assign ext_rd_hit_v[g] = rd_hit && (rd_sel == 2'(g));
        assign sw_in_take[g] = i_rd && (i_addr == ((g < 2) ? ppa_pkg::OFS_IN_WORD_ONE
            : ppa_pkg::OFS_IN_WORD_TWO)); // [R09]
        assign sw_out_load[g] = i_wr && (i_addr == ((g < 2) ? ppa_pkg::OFS_OUT_WORD_ONE
            : ppa_pkg::OFS_OUT_WORD_TWO)); // [R12]
        ppa_byte_slot u_slot
        (
            .i_mclk(i_mclk),
            .i_rst(i_rst),
            .i_ext_wr_hit(ext_wr_hit_v[g]),
            .i_ext_rd_hit(ext_rd_hit_v[g]),
            .i_ext_byte(i_ext_data),
            .i_sw_in_take(sw_in_take[g]),
            .i_sw_out_load(sw_out_load[g]),
            .i_sw_byte(i_wr_data[(g % 2) * 8 +: 8]),
            .o_in_byte(in_byte[g]),
            .o_in_full(input_buffer_full_flags[g]),
            .o_out_byte(out_byte[g]),
            .o_out_empty(output_buffer_empty_flags[g])
        );
    end

    // ========================================================================
    // Next state of registers, pointers, slave data and interrupt
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.wr_prev = i_ext_wr;
        st_nxt.rd_prev = i_ext_rd;
        if (i_wr)
        begin
            case (i_addr)
                ppa_pkg::OFS_TARGET:
                begin
                    st_nxt.chip_select_one_ctl = i_wr_data[ppa_pkg::CS_CTL_BIT]; // [R01]
                    st_nxt.location = i_wr_data[10:0]; // [R02]
                end
                ppa_pkg::OFS_PIN_EN:
                begin
                    st_nxt.select_pad_enable = i_wr_data[ppa_pkg::SEL_PAD_BIT]; // [R03]
                    st_nxt.location_pad_enables = i_wr_data[10:0]; // [R04] [R05]
                end
                ppa_pkg::OFS_BUF_STATE:
                begin
                    st_nxt.input_overflow = i_wr_data[ppa_pkg::IN_OVF_BIT];
                    st_nxt.output_underflow = i_wr_data[ppa_pkg::OUT_UNF_BIT];
                end
                ppa_pkg::OFS_PAD_CFG:
                begin
                    st_nxt.pad_cfg = i_wr_data[2:0];
                end
                ppa_pkg::OFS_CONTROL:
                begin
                    st_nxt.port_on = i_wr_data[ppa_pkg::PORT_ON_BIT];
                    st_nxt.interrupt_request_select = i_wr_data[ppa_pkg::IRQ_SEL_LSB +: 2];
                    st_nxt.port_mode_field = i_wr_data[ppa_pkg::MODE_LSB +: 2];
                end
                ppa_pkg::OFS_IRQ_STATUS:
                begin
                    st_nxt.irq_status = st_r.irq_status & ~i_wr_data[2:0];
                end
                ppa_pkg::OFS_IRQ_MASK:
                begin
                    st_nxt.irq_mask = i_wr_data[2:0];
                end
                default:
                begin
                end
            endcase
        end
        // Hardware sets win over software clears
        if (ev_ovf)
        begin
            st_nxt.input_overflow = 1'b1; // [R08]
        end
        if (ev_unf)
        begin
            st_nxt.output_underflow = 1'b1; // [R11]
        end
        st_nxt.irq_status = st_nxt.irq_status | {ev_cyc, ev_unf, ev_ovf};
        st_nxt.irq = |(st_nxt.irq_status & st_nxt.irq_mask);
        // Running pointers of the buffered mode
        if (wr_hit && st_r.port_mode_field == ppa_pkg::MODE_LEGACY)
        begin
            st_nxt.in_ptr = st_r.in_ptr + 2'h1;
        end
        if (rd_hit && st_r.port_mode_field == ppa_pkg::MODE_LEGACY)
        begin
            st_nxt.out_ptr = st_r.out_ptr + 2'h1;
        end
        // Slave read data and bus drive
        if (rd_hit)
        begin
            st_nxt.ext_dout = out_byte[rd_sel];
        end
        st_nxt.ext_oe_n = !(slave_on && i_ext_cs && i_ext_rd);
        // Register read, valid one cycle after the strobe
        st_nxt.rd_data = '0;
        if (i_rd)
        begin
            case (i_addr)
                ppa_pkg::OFS_TARGET: st_nxt.rd_data = {1'b0, st_r.chip_select_one_ctl, 3'h0,
                    st_r.location}; // [R06]
                ppa_pkg::OFS_PIN_EN: st_nxt.rd_data = {1'b0, st_r.select_pad_enable, 3'h0,
                    st_r.location_pad_enables}; // [R06]
                ppa_pkg::OFS_BUF_STATE: st_nxt.rd_data = status_word;
                ppa_pkg::OFS_PAD_CFG: st_nxt.rd_data = {13'h0, st_r.pad_cfg};
                ppa_pkg::OFS_IN_WORD_ONE: st_nxt.rd_data = {in_byte[1], in_byte[0]};
                ppa_pkg::OFS_IN_WORD_TWO: st_nxt.rd_data = {in_byte[3], in_byte[2]};
                ppa_pkg::OFS_OUT_WORD_ONE: st_nxt.rd_data = {out_byte[1], out_byte[0]};
                ppa_pkg::OFS_OUT_WORD_TWO: st_nxt.rd_data = {out_byte[3], out_byte[2]};
                ppa_pkg::OFS_CONTROL: st_nxt.rd_data = {st_r.port_on,
                    st_r.interrupt_request_select, 3'h0, st_r.port_mode_field, 8'h00};
                ppa_pkg::OFS_IRQ_STATUS: st_nxt.rd_data = {13'h0, st_r.irq_status};
                ppa_pkg::OFS_IRQ_MASK: st_nxt.rd_data = {13'h0, st_r.irq_mask};
                default: st_nxt.rd_data = '0;
            endcase
        end
    end

    // State register
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st_r <= '0;
            st_r.ext_oe_n <= ppa_pkg::RST_OE_N;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ========================================================================
    // Outputs, all from the state register
    assign o_rd_data = st_r.rd_data;
    assign o_ext_data = st_r.ext_dout;
    assign o_ext_data_oe_n = st_r.ext_oe_n;
    assign o_location_pins = st_r.location; // [R02]
    assign o_location_pad_sel = st_r.location_pad_enables; // [R04] [R05]
    assign o_chip_select_one_pin = st_r.chip_select_one_ctl; // [R01]
    assign o_chip_select_pad_sel = st_r.select_pad_enable; // [R03]
    assign o_ttl_input_sel = st_r.pad_cfg[0];
    assign o_irq = st_r.irq;

    // ========================================================================
    // Assertions
    property p_cs_write;
        @(posedge i_mclk) disable iff (i_rst)
        (i_wr && i_addr == ppa_pkg::OFS_TARGET) |=> o_chip_select_one_pin == $past(i_wr_data[14]);
    endproperty
    a_cs_write: assert property (p_cs_write) else $error("chip select not taken"); // [R01]

    property p_loc_write;
        @(posedge i_mclk) disable iff (i_rst)
        (i_wr && i_addr == ppa_pkg::OFS_TARGET) |=> o_location_pins == $past(i_wr_data[10:0]);
    endproperty
    a_loc_write: assert property (p_loc_write) else $error("address not taken"); // [R02]

    property p_pad_sel;
        @(posedge i_mclk) disable iff (i_rst)
        (i_wr && i_addr == ppa_pkg::OFS_PIN_EN) |=> o_chip_select_pad_sel == $past(i_wr_data[14])
            && o_location_pad_sel == $past(i_wr_data[10:0]);
    endproperty
    a_pad_sel: assert property (p_pad_sel) else $error("pad enables not taken"); // [R03]

    property p_unused_zero;
        @(posedge i_mclk) disable iff (i_rst)
        (i_rd && (i_addr == ppa_pkg::OFS_TARGET || i_addr == ppa_pkg::OFS_PIN_EN))
            |=> o_rd_data[15] == 1'b0 && o_rd_data[13:11] == 3'h0;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused bits not zero"); // [R06]

    property p_all_full;
        @(posedge i_mclk) disable iff (i_rst)
        (i_rd && i_addr == ppa_pkg::OFS_BUF_STATE)
            |=> o_rd_data[15] == &$past(input_buffer_full_flags)
            && o_rd_data[7] == &$past(output_buffer_empty_flags);
    endproperty
    a_all_full: assert property (p_all_full) else $error("summary flags wrong"); // [R07]

    property p_overflow;
        @(posedge i_mclk) disable iff (i_rst)
        ev_ovf |=> st_r.input_overflow ##1 (st_r.input_overflow
            || $past(i_wr && i_addr == ppa_pkg::OFS_BUF_STATE));
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow not sticky"); // [R08]

    property p_underflow;
        @(posedge i_mclk) disable iff (i_rst)
        ev_unf |=> st_r.output_underflow;
    endproperty
    a_underflow: assert property (p_underflow) else $error("underflow not set"); // [R11]

    property p_store;
        @(posedge i_mclk) disable iff (i_rst)
        (wr_hit && !input_buffer_full_flags[wr_sel])
            |=> input_buffer_full_flags[$past(wr_sel)] && in_byte[$past(wr_sel)] == $past(i_ext_data);
    endproperty
    a_store: assert property (p_store) else $error("byte not stored"); // [R16]

    property p_last_slot_irq;
        @(posedge i_mclk) disable iff (i_rst)
        (st_r.interrupt_request_select == ppa_pkg::IRQ_LAST_SLOT
            && st_r.port_mode_field == ppa_pkg::MODE_ADDRESSED && wr_hit
            && i_buffer_select_lines == 2'h3) |=> st_r.irq_status[2];
    endproperty
    a_last_slot_irq: assert property (p_last_slot_irq) else $error("slot 3 event lost"); // [R15]

endmodule

// ### bench/ppa_ext_master.sv
// Behavioural external parallel master for the slave byte slots
`timescale 1ns/1ns
module ppa_ext_master
(
    // Clock
    input wire logic i_mclk,
    // Device data pads
    input wire logic [7:0] i_data,
    input wire logic i_data_oe_n,
    // Master lines
    output logic o_cs,
    output logic o_rd,
    output logic o_wr,
    output logic [1:0] o_sel,
    output logic [7:0] o_data
);
    // Idle lines at time zero
    initial
    begin
        o_cs = 1'b0;
        o_rd = 1'b0;
        o_wr = 1'b0;
        o_sel = 2'h0;
        o_data = 8'hA5;
    end

    // Select and slot lines settle a cycle ahead of the strobe
    task automatic setup(input logic [1:0] sel);
        @(posedge i_mclk);
        o_cs <= 1'b1;
        o_sel <= sel;
    endtask

    // Strobe dropped first, then select released and lines scrambled
    task automatic finish(input logic [7:0] last);
        @(posedge i_mclk);
        o_rd <= 1'b0;
        o_wr <= 1'b0;
        @(posedge i_mclk);
        o_cs <= 1'b0;
        o_sel <= ~o_sel;
        o_data <= ~last;
    endtask

    // One byte written into a slot
    task automatic write_byte(input logic [1:0] sel, input logic [7:0] b);
        setup(sel);
        o_data <= b;
        @(posedge i_mclk);
        o_wr <= 1'b1;
        @(posedge i_mclk);
        finish(b);
    endtask

    // One byte read from a slot, taken once the device has answered
    task automatic read_byte(input logic [1:0] sel, output logic [7:0] b);
        setup(sel);
        @(posedge i_mclk);
        o_rd <= 1'b1;
        repeat (2) @(posedge i_mclk);
        // Undriven pads read back inverted, so a missing drive shows up
        #1 b = i_data_oe_n ? ~i_data : i_data;
        finish(o_data);
    endtask
endmodule

// ### bench/ppa_port_tb.sv
// Self-checking bench for the parallel port address and slot status block
`timescale 1ns/1ns
module ppa_port_tb;
    logic i_mclk, i_rst, i_wr, i_rd, cs, xrd, xwr, oe_n, cs_pin, cs_sel, ttl, irq;
    logic [3:0] i_addr, full, emp;
    logic [15:0] i_wr_data, o_rd_data, v, r;
    logic [31:0] w;
    logic [1:0] sel;
    logic [7:0] xin, xout, rb;
    logic [7:0] b [4];
    logic [10:0] loc, loc_sel;
    int num_errors, check_count, seed, s;

    ppa_port dut_u (.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wr_data(i_wr_data),
        .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data), .i_ext_cs(cs), .i_ext_rd(xrd),
        .i_ext_wr(xwr), .i_buffer_select_lines(sel), .i_ext_data(xin), .o_ext_data(xout),
        .o_ext_data_oe_n(oe_n), .o_location_pins(loc), .o_location_pad_sel(loc_sel),
        .o_chip_select_one_pin(cs_pin), .o_chip_select_pad_sel(cs_sel),
        .o_ttl_input_sel(ttl), .o_irq(irq));
    ppa_ext_master ext_u (.i_mclk(i_mclk), .i_data(xout), .i_data_oe_n(oe_n), .o_cs(cs),
        .o_rd(xrd), .o_wr(xwr),
        .o_sel(sel), .o_data(xin));

    // 100 MHz clock
    initial
    begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end

    // Expected status word
    function automatic logic [15:0] exp_st(input logic [3:0] f, input logic [3:0] e,
        input logic ov, input logic un);
        exp_st = {&f, ov, 2'h0, f, &e, un, 2'h0, e};
    endfunction

    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wr_data <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 d = o_rd_data;
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Watchdog
    initial
    begin
        #100000;
        num_errors++;
        tally_and_finish();
    end

    // Main sequence
    initial
    begin
        seed = 32'h313F;
        i_rst = 1'b1;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 4'h0;
        i_wr_data = 16'h0000;
        repeat (6) @(posedge i_mclk);
        i_rst <= 1'b0;
        reg_rd(ppa_pkg::OFS_BUF_STATE, r);
        check("status_rst", r, 16'h008F);
        $display("test reset done");
        for (int k = 0; k < 6; k++)
        begin
            v = (k == 0) ? 16'hFFFF : 16'($random(seed));
            reg_wr(ppa_pkg::OFS_TARGET, v);
            reg_wr(ppa_pkg::OFS_PIN_EN, ~v);
            reg_wr(ppa_pkg::OFS_PAD_CFG, v);
            reg_rd(ppa_pkg::OFS_TARGET, r);
            check("target", r, v & 16'h47FF);
            check("cs_pin", 16'(cs_pin), 16'(v[14]));
            check("loc_pins", 16'(loc), 16'(v[10:0]));
            reg_rd(ppa_pkg::OFS_PIN_EN, r);
            check("pin_en", r, ~v & 16'h47FF);
            check("cs_sel", 16'(cs_sel), {15'h0000, !v[14]});
            check("pad_sel", 16'(loc_sel), {5'h00, ~v[10:0]});
            check("ttl", 16'(ttl), 16'(v[0]));
            reg_rd(ppa_pkg::OFS_PAD_CFG, r);
            check("pad_cfg", r, v & 16'h0007);
        end
        $display("test registers done");
        reg_wr(ppa_pkg::OFS_CONTROL, 16'hE100);
        reg_wr(ppa_pkg::OFS_IRQ_MASK, 16'h0007);
        full = 4'h0;
        emp = 4'hF;
        for (int k = 0; k < 4; k++)
        begin
            b[k] = 8'($random(seed));
            ext_u.write_byte(2'(k), b[k]);
            full[k] = 1'b1;
            reg_rd(ppa_pkg::OFS_BUF_STATE, r);
            check("status_in", r, exp_st(full, emp, 1'b0, 1'b0));
        end
        ext_u.write_byte(2'h1, ~b[1]);
        reg_rd(ppa_pkg::OFS_BUF_STATE, r);
        check("overflow", r, exp_st(full, emp, 1'b1, 1'b0));
        reg_rd(ppa_pkg::OFS_IN_WORD_ONE, r);
        check("word_one", r, {b[1], b[0]});
        reg_rd(ppa_pkg::OFS_IN_WORD_TWO, r);
        check("word_two", r, {b[3], b[2]});
        reg_rd(ppa_pkg::OFS_BUF_STATE, r);
        check("full_clr", r, exp_st(4'h0, emp, 1'b1, 1'b0));
        reg_wr(ppa_pkg::OFS_BUF_STATE, 16'h0000);
        reg_rd(ppa_pkg::OFS_IRQ_STATUS, r);
        check("irq_st", r, 16'h0005);
        check("irq_on", 16'(irq), 16'h0001);
        reg_wr(ppa_pkg::OFS_IRQ_STATUS, 16'h0007);
        reg_rd(ppa_pkg::OFS_BUF_STATE, r);
        check("ovf_clr", r, exp_st(4'h0, emp, 1'b0, 1'b0));
        check("irq_off", 16'(irq), 16'h0000);
        $display("test input slots done");
        v = 16'($random(seed));
        w = {~v, v};
        reg_wr(ppa_pkg::OFS_OUT_WORD_ONE, v);
        reg_wr(ppa_pkg::OFS_OUT_WORD_TWO, ~v);
        emp = 4'h0;
        reg_rd(ppa_pkg::OFS_BUF_STATE, r);
        check("status_out", r, exp_st(4'h0, emp, 1'b0, 1'b0));
        for (int k = 0; k < 4; k++)
        begin
            s = 3 - k;
            ext_u.read_byte(2'(s), rb);
            check("ext_byte", 16'(rb), 16'(w[8*s +: 8]));
            emp[s] = 1'b1;
            reg_rd(ppa_pkg::OFS_BUF_STATE, r);
            check("status_drain", r, exp_st(4'h0, emp, 1'b0, 1'b0));
        end
        ext_u.read_byte(2'h2, rb);
        reg_rd(ppa_pkg::OFS_BUF_STATE, r);
        check("underflow", r, exp_st(4'h0, emp, 1'b0, 1'b1));
        reg_wr(ppa_pkg::OFS_IRQ_MASK, 16'h0000);
        reg_rd(4'hF, r);
        check("unmapped", r, 16'h0000);
        check("irq_masked", 16'(irq), 16'h0000);
        reg_wr(ppa_pkg::OFS_IRQ_MASK, 16'h0007);
        reg_rd(ppa_pkg::OFS_IRQ_STATUS, r);
        check("irq_unf", r, 16'h0006);
        check("irq_unmasked", 16'(irq), 16'h0001);
        reg_wr(ppa_pkg::OFS_IRQ_STATUS, 16'h0007);
        reg_wr(ppa_pkg::OFS_BUF_STATE, 16'h0000);
        reg_rd(ppa_pkg::OFS_BUF_STATE, r);
        check("unf_clr", r, exp_st(4'h0, emp, 1'b0, 1'b0));
        check("irq_clr", 16'(irq), 16'h0000);
        $display("test output slots done");
        // Buffered mode: running pointer picks the slot, address lines ignored
        reg_wr(ppa_pkg::OFS_CONTROL, 16'hE000);
        for (int k = 0; k < 4; k++)
        begin
            b[k] = 8'($random(seed));
            ext_u.write_byte(2'(3 - k), b[k]);
        end
        reg_rd(ppa_pkg::OFS_IN_WORD_ONE, r);
        check("legacy_one", r, {b[1], b[0]});
        reg_rd(ppa_pkg::OFS_IN_WORD_TWO, r);
        check("legacy_two", r, {b[3], b[2]});
        reg_rd(ppa_pkg::OFS_IRQ_STATUS, r);
        check("legacy_irq", r, 16'h0004);
        $display("test buffered slots done");
        tally_and_finish();
    end
endmodule
